// ===== receive_output_formatter.sv
// Overview of operation
// [RL1] Host digital-loss disable bit masks detector
// [RL2] Both disables set: loss never declared
// [RL3] Muted channel drives both rails low
// [RL4] Data resumes once loss clears
// [RL5] Mute strap mutes all channels
// [RL6] Host mute bit mutes one channel
// [RL7] Dual rail updates on clock rising edge
// [RL8] Output clock follows recovered line clock
// [RL9] Line pulse polarity selects rail pulse
// [RL10] Invert strap launches on falling edge
// [RL11] Host invert bit inverts channel clock
// [RL12] Host single-rail bit selects binary stream
// [RL13] Single rail: binary data on positive rail
// [RL14] Strap high selects single rail globally
// [RL15] Strap low selects dual rail globally
// [RL16] Single rail holds negative rail low
// [RL17] Loss is OR of analog, digital
// [RL18] Muting uses loss after disable masks
// [RL19] Terminal samples on opposite clock edge
module receive_output_formatter (
	input  wire logic                         clk_i,               // 50 MHz
	input  wire logic                         srst_i,              // Sync reset
	input  wire logic [11:0]                  paddr_i,             // APB addr
	input  wire logic                         psel_i,              // APB select
	input  wire logic                         penable_i,           // APB enable
	input  wire logic                         pwrite_i,            // APB write
	input  wire logic [31:0]                  pwdata_i,            // APB wdata
	output logic      [31:0]                  prdata_o,            // APB rdata
	output logic                              pready_o,            // APB ready
	output logic                              pslverr_o,           // APB error
	input  wire logic                         host_mode_strap_i,   // Host mode
	input  wire logic                         mute_on_signal_loss_strap_i, // Mute
	input  wire logic                         recovered_clock_invert_strap_i, // Inv
	input  wire logic                         single_rail_select_strap_i, // SR
	input  wire rx_format_pkg::rx_line_t [2:0] line_i,            // Line side
	output rx_format_pkg::rx_rail_t      [2:0] rail_o,            // Terminal side
	output rx_format_pkg::ch_ctrl_t      [2:0] ctrl_o,            // Controls
	output logic      [2:0]                   signal_loss_indication_o, // Loss
	output logic                              irq_o                // Interrupt
);

	// Strap synchroniser stages and filtered strap levels
	logic [3:0]  strap_raw;
	logic [3:0]  s1_q;
	logic [3:0]  s2_q;
	logic [3:0]  s3_q;
	logic [3:0]  strap_q;
	logic [3:0]  strap_d;

	// Software registers
	logic [4:0]  loss_detect_config_q [3];
	logic [4:0]  loss_detect_config_d [3];
	logic [4:0]  receive_output_config_q [3];
	logic [4:0]  receive_output_config_d [3];
	logic [5:0]  irq_stat_q;
	logic [5:0]  irq_stat_d;
	logic [5:0]  irq_mask_q;
	logic [5:0]  irq_mask_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// Bus decode
	logic        hit;
	logic        wr_en;
	logic        setup;
	logic [31:0] rd_val;
	logic [2:0]  sel_loss;
	logic [2:0]  sel_out;
	logic        sel_status;
	logic        sel_irq_stat;
	logic        sel_irq_mask;

	// Per-channel datapath state
	logic        host_mode;
	logic [2:0]  digital_signal_loss_dis;
	logic [2:0]  analog_signal_loss_dis;
	logic [2:0]  mute_en;
	logic [2:0]  clk_inv;
	logic [2:0]  single_rail;
	logic [2:0]  los_q;
	logic [2:0]  los_d;
	logic [2:0]  rec_prev_q;
	logic [2:0]  rec_prev_d;
	logic [2:0]  clk_out_q;
	logic [2:0]  clk_out_d;
	logic [2:0]  pos_q;
	logic [2:0]  pos_d;
	logic [2:0]  neg_q;
	logic [2:0]  neg_d;
	logic [5:0]  events;

	// Gather the strap pins into one vector
	assign strap_raw[rx_format_pkg::STRAP_HOST] = host_mode_strap_i;
	assign strap_raw[rx_format_pkg::STRAP_MUTE] = mute_on_signal_loss_strap_i;
	assign strap_raw[rx_format_pkg::STRAP_INV]  = recovered_clock_invert_strap_i;
	assign strap_raw[rx_format_pkg::STRAP_SR]   = single_rail_select_strap_i;

	// A strap level is accepted only when stages two and three agree
	always_comb begin
		strap_d = (s2_q & s3_q) | (strap_q & (s2_q ^ s3_q));
	end

	// Strap synchroniser registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s1_q    <= rx_format_pkg::STRAP_RST;
			s2_q    <= rx_format_pkg::STRAP_RST;
			s3_q    <= rx_format_pkg::STRAP_RST;
			strap_q <= rx_format_pkg::STRAP_RST;
		end else begin
			s1_q    <= strap_raw;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			strap_q <= strap_d;
		end
	end

	// Effective per-channel settings from registers or straps
	always_comb begin
		host_mode = strap_q[rx_format_pkg::STRAP_HOST];
		for (int c = 0; c < 3; c++) begin
			if (host_mode) begin
				digital_signal_loss_dis[c]    = loss_detect_config_q[c][rx_format_pkg::DIGITAL_SIGNAL_LOSS_DIS_BIT]; // [RL1]
				analog_signal_loss_dis[c]    = loss_detect_config_q[c][rx_format_pkg::ANALOG_SIGNAL_LOSS_DIS_BIT];
				mute_en[c]     = receive_output_config_q[c][rx_format_pkg::MUTE_BIT]; // [RL6]
				clk_inv[c]     = receive_output_config_q[c][rx_format_pkg::CLK_INV_BIT]; // [RL11]
				single_rail[c] = receive_output_config_q[c][rx_format_pkg::SR_BIT]; // [RL12]
			end else begin
				digital_signal_loss_dis[c]    = 1'b0;
				analog_signal_loss_dis[c]    = 1'b0;
				mute_en[c]     = strap_q[rx_format_pkg::STRAP_MUTE]; // [RL5]
				clk_inv[c]     = strap_q[rx_format_pkg::STRAP_INV]; // [RL10]
				single_rail[c] = strap_q[rx_format_pkg::STRAP_SR]; // [RL14] [RL15]
			end
		end
	end

	// Loss state and output clock every cycle, rails launched once per recovered clock cycle
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			// Masked detectors ORed together
			los_d[c] = (line_i[c].analog_signal_loss & ~analog_signal_loss_dis[c]) |
				(line_i[c].digital_signal_loss & ~digital_signal_loss_dis[c]); // [RL2] [RL17]
			rec_prev_d[c] = line_i[c].rec_clk;
			// Output clock tracks the recovered clock, optionally inverted
			clk_out_d[c] = line_i[c].rec_clk ^ clk_inv[c]; // [RL8] [RL10] [RL11]
			pos_d[c] = pos_q[c];
			neg_d[c] = neg_q[c];
			// Launch on the recovered clock rising edge
			if (line_i[c].rec_clk && !rec_prev_q[c]) begin // [RL7] [RL19]
				if (mute_en[c] && los_q[c]) begin // [RL3] [RL18]
					pos_d[c] = 1'b0;
					neg_d[c] = 1'b0;
				end else if (single_rail[c]) begin
					pos_d[c] = line_i[c].bin; // [RL13]
					neg_d[c] = 1'b0;
				end else begin
					pos_d[c] = line_i[c].pos; // [RL9] [RL4]
					neg_d[c] = line_i[c].neg; // [RL9]
				end
			end
			if (single_rail[c]) begin
				neg_d[c] = 1'b0; // [RL16]
			end
		end
	end

	// Datapath registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			los_q      <= 3'h0;
			rec_prev_q <= 3'h0;
			clk_out_q  <= 3'h0;
			pos_q      <= 3'h0;
			neg_q      <= 3'h0;
		end else begin
			los_q      <= los_d;
			rec_prev_q <= rec_prev_d;
			clk_out_q  <= clk_out_d;
			pos_q      <= pos_d;
			neg_q      <= neg_d;
		end
	end

	// Loss edges raise interrupt events
	assign events[rx_format_pkg::IRQ_RISE_POS +: 3] = los_d & ~los_q;
	assign events[rx_format_pkg::IRQ_FALL_POS +: 3] = ~los_d & los_q;

	// APB address decode
	always_comb begin
		sel_loss     = 3'h0;
		sel_out      = 3'h0;
		sel_status   = 1'b0;
		sel_irq_stat = 1'b0;
		sel_irq_mask = 1'b0;
		for (int c = 0; c < 3; c++) begin
			if (paddr_i == rx_format_pkg::LOSS_CFG_OFS +
				12'(c) * rx_format_pkg::CH_STRIDE) begin
				sel_loss[c] = 1'b1;
			end else if (paddr_i == rx_format_pkg::OUT_CFG_OFS +
				12'(c) * rx_format_pkg::CH_STRIDE) begin
				sel_out[c] = 1'b1;
			end
		end
		if (paddr_i == rx_format_pkg::STATUS_OFS) begin
			sel_status = 1'b1;
		end else if (paddr_i == rx_format_pkg::IRQ_STAT_OFS) begin
			sel_irq_stat = 1'b1;
		end else if (paddr_i == rx_format_pkg::IRQ_MASK_OFS) begin
			sel_irq_mask = 1'b1;
		end
		hit = (|sel_loss) | (|sel_out) | sel_status | sel_irq_stat |
			sel_irq_mask;
	end

	// Read value of the addressed register
	always_comb begin
		rd_val = 32'h0000_0000;
		for (int c = 0; c < 3; c++) begin
			if (sel_loss[c]) begin
				rd_val[4:0] = loss_detect_config_q[c];
			end
			if (sel_out[c]) begin
				rd_val[4:0] = receive_output_config_q[c];
			end
		end
		if (sel_status) begin
			rd_val[rx_format_pkg::ST_LOS_POS +: 3] = los_q;
			for (int c = 0; c < 3; c++) begin
				rd_val[rx_format_pkg::ST_ANALOG_SIGNAL_LOSS_POS + c] =
					line_i[c].analog_signal_loss;
				rd_val[rx_format_pkg::ST_DIGITAL_SIGNAL_LOSS_POS + c] =
					line_i[c].digital_signal_loss;
			end
			rd_val[rx_format_pkg::ST_SR_POS +: 3] = single_rail;
			rd_val[rx_format_pkg::ST_HOST_POS] = host_mode;
		end else if (sel_irq_stat) begin
			rd_val[5:0] = irq_stat_q;
		end else if (sel_irq_mask) begin
			rd_val[5:0] = irq_mask_q;
		end
	end

	// Read data is captured in setup so that it comes from a flop
	assign setup = psel_i & ~penable_i;
	assign wr_en = psel_i & penable_i & pwrite_i & hit;

	// Register next values; hardware set wins over a write-one clear
	always_comb begin
		rdata_d = setup ? rd_val : rdata_q;
		for (int c = 0; c < 3; c++) begin
			loss_detect_config_d[c] = loss_detect_config_q[c];
			receive_output_config_d[c] = receive_output_config_q[c];
			if (wr_en && sel_loss[c]) begin
				loss_detect_config_d[c] = pwdata_i[4:0] &
					rx_format_pkg::LOSS_CFG_USED;
			end
			if (wr_en && sel_out[c]) begin
				receive_output_config_d[c] = pwdata_i[4:0] &
					rx_format_pkg::OUT_CFG_USED;
			end
		end
		irq_mask_d = irq_mask_q;
		if (wr_en && sel_irq_mask) begin
			irq_mask_d = pwdata_i[5:0];
		end
		irq_stat_d = irq_stat_q;
		if (wr_en && sel_irq_stat) begin
			irq_stat_d = irq_stat_q & ~pwdata_i[5:0];
		end
		irq_stat_d = irq_stat_d | events;
	end

	// Software register flops
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int c = 0; c < 3; c++) begin
				loss_detect_config_q[c]    <= rx_format_pkg::LOSS_CFG_RST;
				receive_output_config_q[c] <= rx_format_pkg::OUT_CFG_RST;
			end
			irq_stat_q <= rx_format_pkg::IRQ_RST;
			irq_mask_q <= rx_format_pkg::IRQ_RST;
			rdata_q    <= 32'h0000_0000;
		end else begin
			for (int c = 0; c < 3; c++) begin
				loss_detect_config_q[c]    <= loss_detect_config_d[c];
				receive_output_config_q[c] <= receive_output_config_d[c];
			end
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			rdata_q    <= rdata_d;
		end
	end

	// Bus answers: no wait states, error on unmapped access
	assign prdata_o  = rdata_q;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~hit;
	assign irq_o     = |(irq_stat_q & irq_mask_q);

	// Channel outputs
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			rail_o[c].recovered_clock_out = clk_out_q[c];
			rail_o[c].recv_positive_rail  = pos_q[c];
			rail_o[c].recv_negative_rail  = neg_q[c];
			ctrl_o[c].equalizer_enable = host_mode &
				loss_detect_config_q[c][rx_format_pkg::EQ_EN_BIT];
			ctrl_o[c].line_code_decoder_disable = host_mode &
				loss_detect_config_q[c][rx_format_pkg::DEC_DIS_BIT];
			ctrl_o[c].receiver_shutoff = host_mode &
				receive_output_config_q[c][rx_format_pkg::SHUTOFF_BIT];
		end
	end
	assign signal_loss_indication_o = los_q;

endmodule

// ===== rx_format_pkg.sv
package rx_format_pkg;

	// Channel count and register geometry
	localparam int unsigned NUM_CH = 3;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned CFG_W  = 5;

	// Register map, byte addresses on the APB
	localparam logic [11:0] LOSS_CFG_OFS = 12'h000;
	localparam logic [11:0] OUT_CFG_OFS  = 12'h004;
	localparam logic [11:0] CH_STRIDE    = 12'h008;
	localparam logic [11:0] STATUS_OFS   = 12'h018;
	localparam logic [11:0] IRQ_STAT_OFS = 12'h01C;
	localparam logic [11:0] IRQ_MASK_OFS = 12'h020;

	// Loss-detect configuration fields
	localparam int unsigned EQ_EN_BIT    = 0;
	localparam int unsigned DIGITAL_SIGNAL_LOSS_DIS_BIT = 1;
	localparam int unsigned ANALOG_SIGNAL_LOSS_DIS_BIT = 2;
	localparam int unsigned DEC_DIS_BIT  = 3;

	// Receive output configuration fields
	localparam int unsigned CLK_INV_BIT  = 1;
	localparam int unsigned SHUTOFF_BIT  = 2;
	localparam int unsigned MUTE_BIT     = 3;
	localparam int unsigned SR_BIT       = 4;

	// Reset values and implemented-bit masks
	localparam logic [4:0] LOSS_CFG_RST  = 5'h00;
	localparam logic [4:0] OUT_CFG_RST   = 5'h00;
	localparam logic [4:0] LOSS_CFG_USED = 5'h0F;
	localparam logic [4:0] OUT_CFG_USED  = 5'h1E;

	// Status register fields, three bits each except the one-bit host mode flag
	localparam int unsigned ST_LOS_POS   = 0;
	localparam int unsigned ST_ANALOG_SIGNAL_LOSS_POS  = 3;
	localparam int unsigned ST_DIGITAL_SIGNAL_LOSS_POS  = 6;
	localparam int unsigned ST_SR_POS    = 9;
	localparam int unsigned ST_HOST_POS  = 12;

	// Interrupt status and mask layout
	localparam int unsigned IRQ_W        = 6;
	localparam int unsigned IRQ_RISE_POS = 0;
	localparam int unsigned IRQ_FALL_POS = 3;
	localparam logic [5:0]  IRQ_RST      = 6'h00;

	// Strap vector positions
	localparam int unsigned STRAP_W      = 4;
	localparam int unsigned STRAP_HOST   = 0;
	localparam int unsigned STRAP_MUTE   = 1;
	localparam int unsigned STRAP_INV    = 2;
	localparam int unsigned STRAP_SR     = 3;
	localparam logic [3:0]  STRAP_RST    = 4'h0;

	// Nominal recovered clock rates in kHz
	localparam int unsigned E3_CLK_KHZ   = 34368;
	localparam int unsigned DS3_CLK_KHZ  = 44736;
	localparam int unsigned STS1_CLK_KHZ = 51840;

	// Recovered line data of one channel from clock recovery and decoder
	typedef struct packed {
		logic rec_clk;
		logic pos;
		logic neg;
		logic bin;
		logic analog_signal_loss;
		logic digital_signal_loss;
	} rx_line_t;

	// Outputs of one channel toward the terminal equipment
	typedef struct packed {
		logic recovered_clock_out;
		logic recv_positive_rail;
		logic recv_negative_rail;
	} rx_rail_t;

	// Controls of one channel for neighbouring receive blocks
	typedef struct packed {
		logic equalizer_enable;
		logic line_code_decoder_disable;
		logic receiver_shutoff;
	} ch_ctrl_t;

endpackage

// ===== rx_format_checker.sv
module rx_format_checker (
	input wire logic                           clk_i,        // Clock
	input wire logic                           srst_i,       // Reset
	input wire logic                           psel_i,       // APB select
	input wire logic                           penable_i,    // APB enable
	input wire logic                           pwrite_i,     // APB write
	input wire logic                           pready_o,     // APB ready
	input wire logic                           pslverr_o,    // APB error
	input wire logic                           host_mode_strap_i, // Host
	input wire logic                           mute_on_signal_loss_strap_i,
	input wire rx_format_pkg::rx_line_t [2:0]  line_i,       // Line side
	input wire rx_format_pkg::rx_rail_t [2:0]  rail_o,       // Rails
	input wire logic [2:0]                     signal_loss_indication_o,
	input wire logic                           irq_o         // Interrupt
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Channel 0 shorthands
	wire lr = line_i[0].rec_clk;
	wire rp = rail_o[0].recv_positive_rail;
	wire rn = rail_o[0].recv_negative_rail;
	wire wr = psel_i && penable_i && pwrite_i;
	property p_pos_launch;
		$changed(rp) |-> $past(lr) && !$past(lr, 2);
	endproperty
	a_pos_launch: assert property (p_pos_launch)
		else $error("rail changed away from a recovered clock rise");
	property p_clk_data;
		$changed(rp) |-> $changed(rail_o[0].recovered_clock_out);
	endproperty
	a_clk_data: assert property (p_clk_data)
		else $error("rail data changed without a clock edge");
	property p_pos_cause;
		$rose(rp) |-> $past(line_i[0].pos || line_i[0].bin);
	endproperty
	a_pos_cause: assert property (p_pos_cause)
		else $error("positive rail pulse without line pulse");
	property p_neg_cause;
		$rose(rn) |-> $past(line_i[0].neg);
	endproperty
	a_neg_cause: assert property (p_neg_cause)
		else $error("negative rail pulse without line pulse");
	property p_loss_cause;
		signal_loss_indication_o[0] |->
			$past(line_i[0].analog_signal_loss || line_i[0].digital_signal_loss);
	endproperty
	a_loss_cause: assert property (p_loss_cause)
		else $error("loss declared with no detector active");
	property p_hw_loss;
		(!host_mode_strap_i)[*6] ##0 line_i[0].analog_signal_loss
			|=> signal_loss_indication_o[0];
	endproperty
	a_hw_loss: assert property (p_hw_loss)
		else $error("analog loss not declared in hardware mode");
	property p_hw_mute;
		(!host_mode_strap_i && mute_on_signal_loss_strap_i &&
			signal_loss_indication_o[0])[*8] ##1
			(!host_mode_strap_i && mute_on_signal_loss_strap_i &&
			signal_loss_indication_o[0]) |=> !rp && !rn;
	endproperty
	a_hw_mute: assert property (p_hw_mute)
		else $error("rails not muted during loss");
	property p_ready;
		psel_i |-> pready_o;
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready low during transfer");
	property p_err;
		pslverr_o |-> psel_i && penable_i;
	endproperty
	a_err: assert property (p_err)
		else $error("error outside access phase");
	property p_irq_fall;
		$fell(irq_o) |-> $past(wr) || $past(wr, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt dropped without a write");
	c_loss: cover property ($rose(signal_loss_indication_o[0]));
	c_irq: cover property ($rose(irq_o));
	c_err: cover property (pslverr_o);
endmodule

bind receive_output_formatter rx_format_checker rx_format_checker_inst (
	.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .pready_o, .pslverr_o,
	.host_mode_strap_i, .mute_on_signal_loss_strap_i, .line_i, .rail_o,
	.signal_loss_indication_o, .irq_o
);

// ===== rx_terminal_model.sv
module rx_terminal_model (
	input  wire logic                    clk_i,  // Clock
	input  wire rx_format_pkg::rx_rail_t rail_i, // Rails of one channel
	input  wire logic                    inv_i,  // Clock inverted
	output logic                         pos_o,  // Sampled positive rail
	output logic                         neg_o,  // Sampled negative rail
	output logic                         lvl_o   // Clock level at launch
);
	logic clk_q;
	// Sample on the clock edge opposite the launch edge
	always @(posedge clk_i) begin
		clk_q <= rail_i.recovered_clock_out;
		if (clk_q != rail_i.recovered_clock_out &&
			rail_i.recovered_clock_out == inv_i) begin
			pos_o <= rail_i.recv_positive_rail;
			neg_o <= rail_i.recv_negative_rail;
		end
		if ($changed(rail_i.recv_positive_rail))
			lvl_o <= rail_i.recovered_clock_out;
	end
endmodule

// ===== test_receive_output_formatter.sv
module test_receive_output_formatter;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] LC0 = rx_format_pkg::LOSS_CFG_OFS;
	localparam logic [11:0] OC0 = rx_format_pkg::OUT_CFG_OFS;
	localparam logic [11:0] OC1 = OC0 + rx_format_pkg::CH_STRIDE;
	localparam logic [31:0] ONE = 32'h0000_0001;
	localparam logic [31:0] SR  = ONE << rx_format_pkg::SR_BIT;
	localparam logic [31:0] INV = ONE << rx_format_pkg::CLK_INV_BIT;
	localparam logic [31:0] MUT = ONE << rx_format_pkg::MUTE_BIT;
	localparam logic [31:0] DD  = ONE << rx_format_pkg::DIGITAL_SIGNAL_LOSS_DIS_BIT;
	localparam logic [31:0] AD  = ONE << rx_format_pkg::ANALOG_SIGNAL_LOSS_DIS_BIT;
	logic        clk_i, srst_i, psel_i, penable_i, pwrite_i, er;
	logic        host_mode_strap_i, mute_on_signal_loss_strap_i;
	logic        recovered_clock_invert_strap_i, single_rail_select_strap_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic        pready_o, pslverr_o, irq_o;
	logic [2:0]  signal_loss_indication_o, pv, nv, bv, av, dv, inv_x;
	wire  [2:0]  p_q, n_q, l_q;
	logic [3:0]  ph;
	int          num_errors, n_tests, cyc;
	rx_format_pkg::rx_line_t [2:0] line_i;
	rx_format_pkg::rx_rail_t [2:0] rail_o;
	rx_format_pkg::ch_ctrl_t [2:0] ctrl_o;
	receive_output_formatter receive_output_formatter_inst (
		.clk_i, .srst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .host_mode_strap_i,
		.mute_on_signal_loss_strap_i, .recovered_clock_invert_strap_i,
		.single_rail_select_strap_i, .line_i, .rail_o, .ctrl_o,
		.signal_loss_indication_o, .irq_o
	);
	// One terminal model per channel
	for (genvar c = 0; c < 3; c++) begin : g_term
		rx_terminal_model rx_terminal_model_inst (
			.clk_i (clk_i),
			.rail_i(rail_o[c]),
			.inv_i (inv_x[c]),
			.pos_o (p_q[c]),
			.neg_o (n_q[c]),
			.lvl_o (l_q[c])
		);
	end
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Line side: recovered clock of four cycles, timeout counter
	always @(posedge clk_i) begin
		ph <= ph + 4'h1;
		cyc <= cyc + 1;
		for (int c = 0; c < 3; c++)
			line_i[c] <= '{ph[1], pv[c], nv[c], bv[c], av[c], dv[c]};
		if (cyc == 5000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// Access ends at the rising edge that samples ready high
		@(posedge clk_i);
		while (pready_o !== 1'b1) @(posedge clk_i);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		// Let the write settle before any check looks at it
		@(negedge clk_i);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
			num_errors++;
		end
	endtask
	task automatic ck3(input logic [2:0] g, input logic [2:0] e);
		chk({29'h0, g}, {29'h0, e});
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// Set line data, then let it reach the terminal side
	task automatic lin(input logic [2:0] p, n, b, a, d);
		@(posedge clk_i);
		{pv, nv, bv, av, dv} <= {p, n, b, a, d};
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task stop_test;
		$display("errors=%0d tests=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		{pv, nv, bv, av, dv, inv_x, ph, line_i} = '0;
		{cyc, num_errors, n_tests} = '0;
		host_mode_strap_i = 1'b1;
		mute_on_signal_loss_strap_i = 1'b0;
		recovered_clock_invert_strap_i = 1'b0;
		single_rail_select_strap_i = 1'b0;
		srst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		lin(3'h0, 3'h0, 3'h0, 3'h0, 3'h0);
		rdc(LC0, {27'h0, rx_format_pkg::LOSS_CFG_RST});
		rdc(OC0, {27'h0, rx_format_pkg::OUT_CFG_RST});
		apb(1'b1, OC1, 32'hFFFF_FFFF);
		rdc(OC1, {27'h0, rx_format_pkg::OUT_CFG_USED});
		apb(1'b1, OC1, 32'h0);
		rdc(12'hFFC, 32'h0);
		chk({31'h0, er}, ONE);
		// Dual rail, both polarities
		lin(3'h7, 3'h0, 3'h0, 3'h0, 3'h0);
		ck3(p_q, 3'h7);
		ck3(l_q, 3'h7);
		lin(3'h0, 3'h7, 3'h0, 3'h0, 3'h0);
		ck3(n_q, 3'h7);
		// Single rail on channel 0 only
		apb(1'b1, OC0, SR);
		lin(3'h0, 3'h7, 3'h1, 3'h0, 3'h0);
		ck3(p_q, 3'h1);
		ck3(n_q, 3'h6);
		// Clock inversion on channel 0, rails idle while it changes
		lin(3'h0, 3'h0, 3'h0, 3'h0, 3'h0);
		apb(1'b1, OC0, INV);
		inv_x <= 3'h1;
		lin(3'h7, 3'h0, 3'h0, 3'h0, 3'h0);
		ck3(l_q, 3'h6);
		// Muting, masks and interrupt on channel 0
		apb(1'b1, OC0, MUT);
		inv_x <= 3'h0;
		lin(3'h7, 3'h0, 3'h0, 3'h1, 3'h1);
		ck3(signal_loss_indication_o, 3'h1);
		ck3(p_q, 3'h6);
		chk({31'h0, irq_o}, 32'h0);
		rdc(rx_format_pkg::IRQ_STAT_OFS, ONE);
		apb(1'b1, rx_format_pkg::IRQ_MASK_OFS, ONE);
		chk({31'h0, irq_o}, ONE);
		apb(1'b1, rx_format_pkg::IRQ_STAT_OFS, ONE);
		lin(3'h7, 3'h0, 3'h0, 3'h1, 3'h1);
		chk({31'h0, irq_o}, 32'h0);
		apb(1'b1, LC0, AD | DD);
		lin(3'h7, 3'h0, 3'h0, 3'h1, 3'h1);
		ck3(signal_loss_indication_o, 3'h0);
		ck3(p_q, 3'h7);
		apb(1'b1, LC0, AD);
		lin(3'h7, 3'h0, 3'h0, 3'h1, 3'h1);
		ck3(signal_loss_indication_o, 3'h1);
		// Hardware mode straps
		apb(1'b1, LC0, 32'h0);
		host_mode_strap_i <= 1'b0;
		mute_on_signal_loss_strap_i <= 1'b1;
		lin(3'h7, 3'h0, 3'h0, 3'h7, 3'h0);
		ck3(p_q, 3'h0);
		mute_on_signal_loss_strap_i <= 1'b0;
		recovered_clock_invert_strap_i <= 1'b1;
		inv_x <= 3'h7;
		lin(3'h0, 3'h0, 3'h0, 3'h0, 3'h0);
		lin(3'h7, 3'h0, 3'h0, 3'h0, 3'h0);
		ck3(l_q, 3'h0);
		single_rail_select_strap_i <= 1'b1;
		lin(3'h0, 3'h7, 3'h7, 3'h0, 3'h0);
		ck3(p_q, 3'h7);
		ck3(n_q, 3'h0);
		single_rail_select_strap_i <= 1'b0;
		lin(3'h0, 3'h7, 3'h7, 3'h0, 3'h0);
		ck3(n_q, 3'h7);
		stop_test();
	end
endmodule
